// ===== src/ddbp_top.sv
// dma controller top: apb registers, channel and cpu/dma bus arbitration
module ddbp_top #(
   parameter int NUM_CH = 2,
   parameter bit HAS_PRIO = 1'b1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // dma memory bus
   output logic mem_req,
   output logic mem_we,
   output logic [23:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // cpu bus request
   input wire logic cpu_req,
   output logic cpu_gnt,
   // interrupt to cpu
   output logic dma_irq
);
   logic [NUM_CH-1:0] ch_req, ch_we, ch_ack, ch_int;
   logic [23:0] ch_addr [NUM_CH];
   logic [31:0] ch_wdata [NUM_CH];
   logic [31:0] ch_rd [NUM_CH];
   logic [1:0] mode_r, mode_nxt, mode;
   logic chrot_r, chrot_nxt, last_ch_r, last_ch_nxt, last_dma_r, last_dma_nxt;
   logic owner_r, owner_nxt, pick, dma_want, dma_win;
   logic mem_req_r, mem_req_nxt, mem_we_r, mem_we_nxt;
   logic [23:0] mem_addr_r, mem_addr_nxt;
   logic [31:0] mem_wdata_r, mem_wdata_nxt, prdata_r, prdata_nxt;
   logic cpu_gnt_r, cpu_gnt_nxt, irq_r, irq_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, setup, acc_wr;

   // true when the address hits a channel page
   function automatic logic ch_hit(input logic [11:0] a, input int ch);
      ch_hit = a[11:8] == 4'h0 && a[7:4] == 4'(ch + 1);
   endfunction

   // true for any mapped, word-aligned register
   function automatic logic map_ok(input logic [11:0] a);
      map_ok = a[1:0] == 2'h0 && a[11:8] == 4'h0
         && ((a[7:4] == ddbp_pkg::GLB_PAGE && a[3:2] == 2'h0)
         || (a[7:4] != ddbp_pkg::GLB_PAGE && int'(a[7:4]) <= NUM_CH));
   endfunction

   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pready_r && pwrite && !pslverr_r;

   //////////////////////////////////////////////////////////////////////
   // channels; NUM_CH instances, the second channel being optional
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [31:0] ctrl_q;
      logic [23:0] src_q, dst_q, cnt_q;
      ddbp_channel u_ch (
         .pclk(pclk),
         .presetn(presetn),
         .wr_en(acc_wr && ch_hit(paddr, i)),
         .wr_idx(paddr[3:2]),
         .wdata(pwdata),
         .ctrl_q(ctrl_q),
         .src_q(src_q),
         .dst_q(dst_q),
         .cnt_q(cnt_q),
         .req(ch_req[i]),
         .req_we(ch_we[i]),
         .req_addr(ch_addr[i]),
         .req_wdata(ch_wdata[i]),
         .ack(ch_ack[i]),
         .rdata(mem_rdata)
      );
      assign ch_ack[i] = mem_req_r && mem_ack && owner_r == 1'(i);
      assign ch_int[i] = ctrl_q[ddbp_pkg::BIT_DONE] && ctrl_q[ddbp_pkg::BIT_IE];
      assign ch_rd[i] = paddr[3:2] == ddbp_pkg::REG_CTRL ? ctrl_q
         : paddr[3:2] == ddbp_pkg::REG_SRC ? {8'h00, src_q}
         : paddr[3:2] == ddbp_pkg::REG_DST ? {8'h00, dst_q} : {8'h00, cnt_q};
   end

   //////////////////////////////////////////////////////////////////////
   // apb: one wait-free access phase; answer prepared during setup
   always_comb begin
      mode_nxt = mode_r;
      chrot_nxt = chrot_r;
      prdata_nxt = prdata_r;
      pready_nxt = setup;
      pslverr_nxt = setup && !map_ok(paddr);
      if (setup && !pwrite) begin
         if (!map_ok(paddr)) begin
            prdata_nxt = ddbp_pkg::WORD_RST;
         end else if (paddr[7:4] == ddbp_pkg::GLB_PAGE) begin
            prdata_nxt = {29'h0000_0000, chrot_r, mode_r};
         end else begin
            prdata_nxt = ch_rd[paddr[5] && NUM_CH > 1];
         end
      end
      if (acc_wr && paddr[7:4] == ddbp_pkg::GLB_PAGE) begin
         mode_nxt = pwdata[ddbp_pkg::BIT_MODE +: 2];
         chrot_nxt = pwdata[ddbp_pkg::BIT_CHROT];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // arbitration; only a free bus is arbitrated, a started word runs out
   always_comb begin
      mode = HAS_PRIO ? mode_r : ddbp_pkg::PRI_CPU;
      dma_want = |ch_req;
      // channel pick: fixed channel 0 first, or alternate when rotating
      pick = NUM_CH > 1 && ch_req[NUM_CH-1]
         && (!ch_req[0] || (chrot_r && !last_ch_r));
      case (mode)
         ddbp_pkg::PRI_DMA: dma_win = dma_want;
         ddbp_pkg::PRI_ROT: dma_win = dma_want && (!cpu_req || !last_dma_r);
         default: dma_win = dma_want && !cpu_req;
      endcase
      mem_req_nxt = mem_req_r;
      mem_we_nxt = mem_we_r;
      mem_addr_nxt = mem_addr_r;
      mem_wdata_nxt = mem_wdata_r;
      owner_nxt = owner_r;
      last_ch_nxt = last_ch_r;
      last_dma_nxt = last_dma_r;
      cpu_gnt_nxt = !mem_req_r && cpu_req && !dma_win;
      if (mem_req_r) begin
         if (mem_ack) begin
            mem_req_nxt = 1'b0;
         end
      end else if (dma_win) begin
         mem_req_nxt = 1'b1;
         mem_we_nxt = ch_we[pick];
         mem_addr_nxt = ch_addr[pick];
         mem_wdata_nxt = ch_wdata[pick];
         owner_nxt = pick;
         last_ch_nxt = pick;
         last_dma_nxt = 1'b1;
      end else if (cpu_req) begin
         last_dma_nxt = 1'b0;
      end
      irq_nxt = |ch_int;
   end

   // register stage; last winner resets to dma so the cpu takes the first turn
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= ddbp_pkg::MODE_RST;
         chrot_r <= 1'b0;
         prdata_r <= ddbp_pkg::WORD_RST;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         mem_req_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_addr_r <= ddbp_pkg::PTR_RST;
         mem_wdata_r <= ddbp_pkg::WORD_RST;
         owner_r <= 1'b0;
         last_ch_r <= 1'b1;
         last_dma_r <= 1'b1;
         cpu_gnt_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         chrot_r <= chrot_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         mem_req_r <= mem_req_nxt;
         mem_we_r <= mem_we_nxt;
         mem_addr_r <= mem_addr_nxt;
         mem_wdata_r <= mem_wdata_nxt;
         owner_r <= owner_nxt;
         last_ch_r <= last_ch_nxt;
         last_dma_r <= last_dma_nxt;
         cpu_gnt_r <= cpu_gnt_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign mem_req = mem_req_r;
   assign mem_we = mem_we_r;
   assign mem_addr = mem_addr_r;
   assign mem_wdata = mem_wdata_r;
   assign cpu_gnt = cpu_gnt_r;
   assign dma_irq = irq_r;

   //////////////////////////////////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_cpu_first: assert property (
      mode == ddbp_pkg::PRI_CPU && cpu_req && !mem_req_r |=> cpu_gnt_r && !mem_req_r)
      else $error("cpu lost priority");
   chk_dma_first: assert property (
      mode == ddbp_pkg::PRI_DMA && dma_want && !mem_req_r |=> mem_req_r && !cpu_gnt_r)
      else $error("dma lost priority");
   chk_rotate_turn: assert property (
      cpu_gnt_r && mode == ddbp_pkg::PRI_ROT && cpu_req && dma_want |=> mem_req_r)
      else $error("rotation skipped dma");
   // after a dma word the cpu, still asking, must take the next turn
   chk_rotate_back: assert property (
      mode == ddbp_pkg::PRI_ROT && mem_req_r && mem_ack
      ##1 mode == ddbp_pkg::PRI_ROT && cpu_req |=> cpu_gnt_r)
      else $error("rotation skipped cpu");
   chk_req_held: assert property (
      mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r))
      else $error("memory request dropped");
   chk_irq_done: assert property (
      |ch_int |=> dma_irq)
      else $error("interrupt missing");
   chk_apb_answer: assert property (
      setup |=> pready ##1 !pready)
      else $error("apb answer timing");
endmodule

// ===== src/ddbp_pkg.sv
// constants and types shared by the dma block
package ddbp_pkg;
   localparam int ADDR_W = 24;
   localparam int APB_AW = 12;
   // global page number and register offsets (word index within a page)
   localparam logic [3:0] GLB_PAGE = 4'h0;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_SRC = 2'h1;
   localparam logic [1:0] REG_DST = 2'h2;
   localparam logic [1:0] REG_CNT = 2'h3;
   // channel control bit positions
   localparam int BIT_START = 0;
   localparam int BIT_SDEC = 1;
   localparam int BIT_DDEC = 2;
   localparam int BIT_IE = 3;
   localparam int BIT_BUSY = 4;
   localparam int BIT_DONE = 5;
   // global control bit positions
   localparam int BIT_MODE = 0;
   localparam int BIT_CHROT = 2;
   // bus priority modes
   localparam logic [1:0] PRI_CPU = 2'h0;
   localparam logic [1:0] PRI_DMA = 2'h1;
   localparam logic [1:0] PRI_ROT = 2'h2;
   // reset values and the one-word pointer step
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [ADDR_W-1:0] PTR_RST = 24'h00_0000;
   localparam logic [ADDR_W-1:0] PTR_ONE = 24'h00_0001;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} ddbp_state_type;
endpackage

// ===== src/ddbp_channel.sv
// one transfer channel: registers, pointers and read-then-write sequencer
module ddbp_channel (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register writes
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [31:0] wdata,
   // register contents
   output logic [31:0] ctrl_q,
   output logic [23:0] src_q,
   output logic [23:0] dst_q,
   output logic [23:0] cnt_q,
   // memory side
   output logic req,
   output logic req_we,
   output logic [23:0] req_addr,
   output logic [31:0] req_wdata,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   ddbp_pkg::ddbp_state_type state_r, state_nxt;
   logic [23:0] src_r, src_nxt, dst_r, dst_nxt, cnt_r, cnt_nxt;
   logic [31:0] data_r, data_nxt;
   logic sdec_r, sdec_nxt, ddec_r, ddec_nxt, ie_r, ie_nxt, done_r, done_nxt;
   logic wr_ctl, idle;

   // one step of a pointer, up or down
   function automatic logic [23:0] step(input logic [23:0] p, input logic dec);
      step = dec ? p - ddbp_pkg::PTR_ONE : p + ddbp_pkg::PTR_ONE;
   endfunction

   assign wr_ctl = wr_en && wr_idx == ddbp_pkg::REG_CTRL;
   assign idle = state_r == ddbp_pkg::ST_IDLE;

   //////////////////////////////////////////////////////////////////////
   // next state; setup writes only land while idle so a block stays coherent
   always_comb begin
      state_nxt = state_r;
      src_nxt = src_r;
      dst_nxt = dst_r;
      cnt_nxt = cnt_r;
      data_nxt = data_r;
      sdec_nxt = sdec_r;
      ddec_nxt = ddec_r;
      ie_nxt = ie_r;
      done_nxt = done_r;
      if (wr_en && idle) begin
         case (wr_idx)
            ddbp_pkg::REG_SRC: src_nxt = wdata[23:0];
            ddbp_pkg::REG_DST: dst_nxt = wdata[23:0];
            ddbp_pkg::REG_CNT: cnt_nxt = wdata[23:0];
            default: ;
         endcase
      end
      if (wr_ctl) begin
         ie_nxt = wdata[ddbp_pkg::BIT_IE];
         if (wdata[ddbp_pkg::BIT_DONE]) begin
            done_nxt = 1'b0;
         end
         if (idle) begin
            sdec_nxt = wdata[ddbp_pkg::BIT_SDEC];
            ddec_nxt = wdata[ddbp_pkg::BIT_DDEC];
         end
      end
      // sets below come after the clear, so a finish beats a clear
      case (state_r)
         ddbp_pkg::ST_IDLE: begin
            if (wr_ctl && wdata[ddbp_pkg::BIT_START]) begin
               if (cnt_r == '0) begin
                  done_nxt = 1'b1;
               end else begin
                  state_nxt = ddbp_pkg::ST_RD;
               end
            end
         end
         ddbp_pkg::ST_RD: begin
            if (ack) begin
               data_nxt = rdata;
               state_nxt = ddbp_pkg::ST_WR;
            end
         end
         ddbp_pkg::ST_WR: begin
            if (ack) begin
               src_nxt = step(src_r, sdec_r);
               dst_nxt = step(dst_r, ddec_r);
               cnt_nxt = cnt_r - ddbp_pkg::PTR_ONE;
               if (cnt_nxt == '0) begin
                  done_nxt = 1'b1;
                  state_nxt = ddbp_pkg::ST_IDLE;
               end else begin
                  state_nxt = ddbp_pkg::ST_RD;
               end
            end
         end
         default: state_nxt = ddbp_pkg::ST_IDLE;
      endcase
   end

   // register stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ddbp_pkg::ST_IDLE;
         src_r <= ddbp_pkg::PTR_RST;
         dst_r <= ddbp_pkg::PTR_RST;
         cnt_r <= ddbp_pkg::PTR_RST;
         data_r <= ddbp_pkg::WORD_RST;
         sdec_r <= 1'b0;
         ddec_r <= 1'b0;
         ie_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         src_r <= src_nxt;
         dst_r <= dst_nxt;
         cnt_r <= cnt_nxt;
         data_r <= data_nxt;
         sdec_r <= sdec_nxt;
         ddec_r <= ddec_nxt;
         ie_r <= ie_nxt;
         done_r <= done_nxt;
      end
   end

   // read phase first, then the write of the captured word
   assign req = !idle;
   assign req_we = state_r == ddbp_pkg::ST_WR;
   assign req_addr = req_we ? dst_r : src_r;
   assign req_wdata = data_r;
   assign ctrl_q = {26'h000_0000, done_r, !idle, ie_r, ddec_r, sdec_r, 1'b0};
   assign src_q = src_r;
   assign dst_q = dst_r;
   assign cnt_q = cnt_r;

   //////////////////////////////////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_word_end;
      state_r == ddbp_pkg::ST_WR && ack;
   endsequence

   chk_read_then_write: assert property (
      state_r == ddbp_pkg::ST_RD && ack |=> req_we && req_wdata == $past(rdata))
      else $error("write did not follow read");
   chk_ptr_step: assert property (
      s_word_end |=> src_r == step($past(src_r), sdec_r) && dst_r == step($past(dst_r), ddec_r))
      else $error("pointers not stepped");
   chk_count_dec: assert property (
      s_word_end |=> cnt_r == $past(cnt_r) - ddbp_pkg::PTR_ONE)
      else $error("count not decremented");
   chk_stop_zero: assert property (
      s_word_end ##0 cnt_r == ddbp_pkg::PTR_ONE |=> idle && done_r)
      else $error("block did not end at zero");
   chk_keep_going: assert property (
      s_word_end ##0 cnt_r != ddbp_pkg::PTR_ONE |=> state_r == ddbp_pkg::ST_RD)
      else $error("transfer stopped early");
endmodule

// ===== testbench/ddbp_mem_model.sv
// memory side model: word store answering dma requests after a set delay
module ddbp_mem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // answer delay in cycles, set by the bench
   input wire logic [3:0] lat,
   // dma memory bus
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:255];
   logic [3:0] wait_r;
   ////////////////////////////////////////////////////////////
   // known pattern per word; only the low address byte decodes
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 32'h1234_0000 | 32'(i);
      end
   end
   // one ack per held request; read lines churn outside the answer
   // so a late sample never sees stale data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0000_0000;
         wait_r <= 4'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && wait_r == lat) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr[7:0]];
         wait_r <= 4'h0;
      end else begin
         wait_r <= mem_req ? wait_r + 4'h1 : 4'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
   // a write lands only at the edge that completes it
   always @(posedge pclk) begin
      if (mem_ack && mem_req && mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
   end
endmodule

// ===== testbench/tb_dsp_dma_with_bus_priority.sv
// self-checking bench for the dma block: registers, moves, bus priority
module tb_dsp_dma_with_bus_priority;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, cpu_req, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, q;
   logic pready, pslverr, mem_req, mem_we, mem_ack, cpu_gnt, dma_irq;
   logic [23:0] mem_addr;
   logic [3:0] lat;
   int miscompares, comparisons;
   ////////////////////////////////////////////////////////////
   // design and far-side model
   ddbp_top #(.NUM_CH(2), .HAS_PRIO(1'b1)) u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_ack, .mem_rdata, .cpu_req, .cpu_gnt, .dma_irq);
   ddbp_mem_model u_mem (
      .pclk, .presetn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata);
   // 4 ns clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer plus an idle edge, so psel never toggles twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 16) begin
         chk(32'h0000_0000, 32'h0000_0001);
         end_sim();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   // poll control until done, bounded
   task automatic wait_done(input logic [11:0] b);
      int n;
      n = 0;
      do begin
         apb(1'b0, b, 32'h0000_0000);
         n++;
      end while (q[ddbp_pkg::BIT_DONE] !== 1'b1 && n < 100);
      if (n >= 100) begin
         chk(32'h0000_0000, 32'h0000_0001);
         end_sim();
      end
   endtask
   // program one block, run it, judge memory, pointers, count and irq
   task automatic run_move(input int ch, input logic [23:0] s, input logic [23:0] d,
         input int n, input logic dec, input logic ie);
      logic [31:0] e [0:8];
      logic [11:0] b;
      logic [23:0] st;
      b = 12'(16 * (ch + 1));
      st = dec ? -24'(n) : 24'(n);
      for (int k = 0; k < n; k++) begin
         e[k] = u_mem.mem[8'(dec ? s - 24'(k) : s + 24'(k))];
      end
      e[8] = u_mem.mem[8'(d + st)];
      wr(b + 12'h004, {8'h00, s});
      wr(b + 12'h008, {8'h00, d});
      wr(b + 12'h00c, 32'(n));
      wr(b, {28'h000_0000, ie, dec, dec, 1'b1});
      wait_done(b);
      for (int k = 0; k < n; k++) begin
         chk(u_mem.mem[8'(dec ? d - 24'(k) : d + 24'(k))], e[k]);
      end
      chk(u_mem.mem[8'(d + st)], e[8]);
      rd(b + 12'h004, {8'h00, s + st});
      rd(b + 12'h008, {8'h00, d + st});
      rd(b + 12'h00c, 32'h0000_0000);
      chk({31'h0000_0000, dma_irq}, {31'h0000_0000, ie});
      wr(b, {26'h000_0000, 1'b1, 1'b0, ie, 3'b000});
      @(posedge pclk);
      chk({31'h0000_0000, dma_irq}, 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////
   // reset values of both channel pages, unmapped and unaligned places
   task automatic t_regs();
      logic [11:0] a [0:8] = '{12'h000, 12'h010, 12'h014, 12'h018, 12'h01c,
         12'h020, 12'h024, 12'h028, 12'h02c};
      foreach (a[i]) begin
         rd(a[i], 32'h0000_0000);
         chk({31'h0000_0000, err}, 32'h0000_0000);
      end
      wr(12'h024, 32'hffff_ffff);
      rd(12'h024, 32'h00ff_ffff);
      wr(12'h030, 32'hffff_ffff);
      rd(12'h030, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      rd(12'h013, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
   endtask
   // up, down with slow memory, peripheral source, second channel, one word
   task automatic t_moves();
      run_move(0, 24'h00_0010, 24'h00_0080, 3, 1'b0, 1'b1);
      lat <= 4'h3;
      run_move(0, 24'h00_0047, 24'h00_00c7, 4, 1'b1, 1'b0);
      lat <= 4'h1;
      run_move(1, 24'h80_8020, 24'h00_00a0, 2, 1'b0, 1'b1);
      run_move(1, 24'h00_0030, 24'h00_00b0, 1, 1'b1, 1'b1);
      lat <= 4'h0;
   endtask
   // a start with count zero finishes at once without touching memory
   task automatic t_zero();
      logic seen;
      seen = 1'b0;
      wr(12'h01c, 32'h0000_0000);
      wr(12'h010, 32'h0000_0001);
      repeat (6) begin
         @(posedge pclk);
         seen = seen | mem_req;
      end
      chk({31'h0000_0000, seen}, 32'h0000_0000);
      rd(12'h010, 32'h0000_0020);
      wr(12'h010, 32'h0000_0020);
   endtask
   // cpu and dma both asking: who wins first, and does each get the bus
   task automatic t_prio(input logic [1:0] m);
      logic fd, ds, gs, any;
      logic [2:0] ex;
      {fd, ds, gs, any} = 4'h0;
      // the cpu holds grants during the start write, so a rotating turn goes to dma
      ex = m == 2'h1 || m == 2'h2 ? 3'b111 : 3'b001;
      wr(12'h000, {30'h0000_0000, m});
      wr(12'h014, 32'h0000_0060);
      wr(12'h018, 32'h0000_00e0);
      wr(12'h01c, 32'h0000_0002);
      cpu_req <= 1'b1;
      wr(12'h010, 32'h0000_0001);
      repeat (30) begin
         @(posedge pclk);
         if (!any && (cpu_gnt || mem_req)) begin
            fd = mem_req;
            any = 1'b1;
         end
         ds = ds | mem_req;
         gs = gs | cpu_gnt;
      end
      chk({29'h0000_0000, fd, ds, gs}, {29'h0000_0000, ex});
      cpu_req <= 1'b0;
      wait_done(12'h010);
      wr(12'h010, 32'h0000_0020);
   endtask
   // both channels busy on slow memory, channel 1 first; fixed order gives
   // channel 0 every later turn until its block ends, rotation gives channel 0 the next one and channel 1 the one after
   task automatic t_chpri(input logic rot);
      logic [23:0] fw;
      logic got;
      fw = 24'h00_0000;
      got = 1'b0;
      lat <= 4'hf;
      wr(12'h000, {29'h0000_0000, rot, 2'b00});
      wr(12'h024, 32'h0000_0050);
      wr(12'h028, 32'h0000_00d0);
      wr(12'h02c, 32'h0000_0001);
      wr(12'h014, 32'h0000_0040);
      wr(12'h018, 32'h0000_00f0);
      wr(12'h01c, 32'h0000_0002);
      wr(12'h020, 32'h0000_0001);
      wr(12'h010, 32'h0000_0001);
      for (int k = 0; k < 200 && !got; k++) begin
         @(posedge pclk);
         if (mem_req && mem_we && mem_ack) begin
            fw = mem_addr;
            got = 1'b1;
         end
      end
      chk({8'h00, fw}, rot ? 32'h0000_00d0 : 32'h0000_00f0);
      wait_done(12'h010);
      wait_done(12'h020);
      lat <= 4'h0;
      chk(u_mem.mem[8'hd0], 32'h1234_0050);
      chk(u_mem.mem[8'hf0], 32'h1234_0040);
      chk(u_mem.mem[8'hf1], 32'h1234_0041);
      wr(12'h010, 32'h0000_0020);
      wr(12'h020, 32'h0000_0020);
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, cpu_req} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      lat = 4'h0;
      miscompares = 0;
      comparisons = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_moves();
      t_zero();
      t_chpri(1'b0);
      t_chpri(1'b1);
      for (int m = 0; m < 4; m++) begin
         t_prio(2'(m));
      end
      end_sim();
   end
endmodule
